// ==== esf_pkg.sv ====
// esf_pkg: constants, types and helpers shared by the sram/fifo block
// assumes one clock domain and an apb master with 32-bit data
package esf_pkg;

    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int ESF_CAP_BITS = 4608;
    localparam int ESF_AW = 12;
    localparam int ESF_DW = 18;
    localparam int ESF_CW = 13;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ESF_CTRL_ADR = 8'h00;
    localparam logic [7:0] ESF_DEPTH_ADR = 8'h04;
    localparam logic [7:0] ESF_AE_ADR = 8'h08;
    localparam logic [7:0] ESF_AF_ADR = 8'h0c;
    localparam logic [7:0] ESF_STAT_ADR = 8'h10;
    localparam logic [7:0] ESF_IST_ADR = 8'h14;
    localparam logic [7:0] ESF_IMSK_ADR = 8'h18;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [12:0] ESF_DEPTH_RST = 13'h0000;
    localparam logic [12:0] ESF_AE_RST = 13'h0001;
    localparam logic [12:0] ESF_AF_RST = 13'h00ff;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ESF_W1, ESF_W2, ESF_W4, ESF_W9, ESF_W18
    } esf_w_e;

    typedef struct packed {
        esf_w_e rd_w;
        esf_w_e wr_w;
        logic fifo_en;
    } esf_ctrl_s;

    typedef struct packed {
        logic ae_rise;
        logic af_rise;
        logic udf;
        logic ovf;
    } esf_irq_s;

    typedef struct packed {
        logic af;
        logic ae;
        logic full;
        logic empty;
    } esf_flags_s;

    typedef struct packed {
        logic en;
        logic [ESF_AW-1:0] addr;
        logic [ESF_DW-1:0] data;
    } esf_wport_s;

    typedef struct packed {
        logic en;
        logic [ESF_AW-1:0] addr;
    } esf_rport_s;

    typedef struct packed {
        esf_ctrl_s ctrl;
        logic [ESF_CW-1:0] depth;
        logic [ESF_CW-1:0] ae_thr;
        logic [ESF_CW-1:0] af_thr;
        logic [ESF_AW-1:0] wptr;
        logic [ESF_AW-1:0] rptr;
        logic [ESF_CW-1:0] cnt;
        esf_flags_s flags;
        esf_irq_s istat;
        esf_irq_s imask;
        logic [31:0] prdata;
        logic pslverr;
        logic rd_valid;
    } esf_state_s;

    // ------------------------------------------------------------
    // aspect ratio helpers
    // ------------------------------------------------------------
    function automatic logic [4:0] esf_width(esf_w_e w);
        unique case (w)
            ESF_W1: return 5'h01;
            ESF_W2: return 5'h02;
            ESF_W4: return 5'h04;
            ESF_W9: return 5'h09;
            ESF_W18: return 5'h12;
            default: return 5'h01;
        endcase
    endfunction : esf_width

    function automatic logic [12:0] esf_depth(esf_w_e w);
        unique case (w)
            ESF_W1: return 13'h1000;
            ESF_W2: return 13'h0800;
            ESF_W4: return 13'h0400;
            ESF_W9: return 13'h0200;
            ESF_W18: return 13'h0100;
            default: return 13'h1000;
        endcase
    endfunction : esf_depth

endpackage : esf_pkg

// ==== esf_core.sv ====
// esf_core: bit-addressed storage array with one write and one read port
// assumes callers pass a bit base and width that stay inside the array
`timescale 1ns/1ps
module esf_core
    import esf_pkg::*;
#(
    parameter int CAP_BITS = ESF_CAP_BITS
) (
    input wire logic clk,
    input wire logic we,
    input wire logic [ESF_CW-1:0] wbase,
    input wire logic [4:0] wwid,
    input wire logic [ESF_DW-1:0] wdata,
    input wire logic re,
    input wire logic [ESF_CW-1:0] rbase,
    input wire logic [4:0] rwid,
    output logic [ESF_DW-1:0] rdata
);

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    // one bit per cell, so any write width can be read at any other
    logic mem [0:CAP_BITS-1];
    logic [ESF_DW-1:0] rdata_q;
    logic [ESF_DW-1:0] rbit;

    if (CAP_BITS < ESF_CAP_BITS) begin : g_cap_chk
        $error("esf_core: capacity too small for widest mode");
    end

    assign rdata = rdata_q;

    // ------------------------------------------------------------
    // per-bit read select and one write process
    // ------------------------------------------------------------
    // the array keeps a single writer process; per-bit muxes feed reads
    for (genvar i = 0; i < ESF_DW; i++) begin : g_bit
        assign rbit[i] = (5'(i) < rwid) ?
            mem[ESF_CW'(rbase + ESF_CW'(i))] : 1'b0; // R4
    end

    // no reset on the array: contents survive reset like a real ram
    always_ff @(posedge clk) begin
        for (int i = 0; i < ESF_DW; i++) begin
            if (we && (5'(i) < wwid)) begin
                mem[ESF_CW'(wbase + ESF_CW'(i))] <= wdata[i]; // R3
            end
        end
        if (re) begin
            rdata_q <= rbit;
        end
    end

endmodule : esf_core

// ==== esf_top.sv ====
// esf_top: embedded sram block with optional fifo control unit
// assumes fabric ports and the preload port run on clk; apb on clk
//
// Functional notes
// R1 - fixed capacity of 4,608 bits per block
// R2 - 256x18, 512x9, 1kx4, 2kx2, 4kx1 organisations
// R3 - independent read and write ports
// R4 - read and write widths chosen separately; fifo mode uses the write width on both ports
// R5 - contents preloadable through the test port
// R6 - fifo mode needs no extra fabric logic
// R7 - fifo width and depth are programmable
// R8 - almost-empty and almost-full with own thresholds
// R9 - empty and full flags driven
// R10 - internal read and write pointer counters
// R11 - blocks cascade into deeper or wider memories
// R12 - push when full, pop when empty ignored
// R13 - almost-empty at/below, almost-full at/above threshold
`timescale 1ns/1ps
module esf_top
    import esf_pkg::*;
#(
    parameter int CAP_BITS = ESF_CAP_BITS
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire esf_wport_s wport,
    input wire esf_rport_s rport,
    output logic [ESF_DW-1:0] rd_data,
    output logic rd_valid,
    input wire esf_wport_s tport,
    output esf_flags_s flags
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (CAP_BITS != ESF_CAP_BITS) begin : g_cap_chk
        $error("esf_top: capacity must equal the block size"); // R1
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    esf_state_s s_q;
    esf_state_s s_d;

    logic [4:0] wwid;
    logic [4:0] rwid;
    logic [ESF_CW-1:0] dmax;
    logic [ESF_CW-1:0] deff;
    logic [ESF_CW-1:0] rdmax;
    logic push;
    logic pop;
    esf_irq_s ev;
    esf_irq_s clr;
    logic setup;
    logic access;
    logic mapped;
    logic [31:0] rd_mux;
    logic core_we;
    logic core_re;
    logic [ESF_DW-1:0] core_wdata;
    logic [ESF_AW-1:0] waddr;
    logic [ESF_AW-1:0] raddr;
    logic [ESF_CW-1:0] wbase;
    logic [ESF_CW-1:0] rbase;

    // ------------------------------------------------------------
    // aspect ratio and effective fifo depth
    // ------------------------------------------------------------
    // the fifo uses the write-port width on both ports
    always_comb begin
        wwid = esf_width(s_q.ctrl.wr_w); // R2
        dmax = esf_depth(s_q.ctrl.wr_w); // R2
        rwid = s_q.ctrl.fifo_en ? wwid : esf_width(s_q.ctrl.rd_w); // R4
        rdmax = s_q.ctrl.fifo_en ? dmax : esf_depth(s_q.ctrl.rd_w);
        // zero or oversize depth means the full block
        if (s_q.depth == '0 || s_q.depth > dmax) begin
            deff = dmax; // R7
        end else begin
            deff = s_q.depth; // R7
        end
    end

    // ------------------------------------------------------------
    // fifo accept terms
    // ------------------------------------------------------------
    // a preload owns the write port, so a push that cycle is refused
    assign push = s_q.ctrl.fifo_en && wport.en && !s_q.flags.full
        && !tport.en; // R12
    assign pop = s_q.ctrl.fifo_en && rport.en && !s_q.flags.empty; // R12

    // ------------------------------------------------------------
    // interrupt events
    // ------------------------------------------------------------
    always_comb begin
        ev.ovf = s_q.ctrl.fifo_en && wport.en
            && (s_q.flags.full || tport.en);
        ev.udf = s_q.ctrl.fifo_en && rport.en && s_q.flags.empty;
        ev.af_rise = s_d.flags.af && !s_q.flags.af;
        ev.ae_rise = s_d.flags.ae && !s_q.flags.ae;
    end

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    assign setup = psel && !penable;
    assign access = psel && penable;

    always_comb begin
        mapped = 1'b1;
        rd_mux = '0;
        unique case (paddr)
            ESF_CTRL_ADR: rd_mux = 32'(s_q.ctrl);
            ESF_DEPTH_ADR: rd_mux = 32'(s_q.depth);
            ESF_AE_ADR: rd_mux = 32'(s_q.ae_thr);
            ESF_AF_ADR: rd_mux = 32'(s_q.af_thr);
            ESF_STAT_ADR: rd_mux = 32'({s_q.cnt, s_q.flags});
            ESF_IST_ADR: rd_mux = 32'(s_q.istat);
            ESF_IMSK_ADR: rd_mux = 32'(s_q.imask);
            default: mapped = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.rd_valid = pop || (!s_q.ctrl.fifo_en && rport.en);
        // pointer counters wrap at the programmed depth
        if (push) begin
            s_d.wptr = (s_q.wptr == ESF_AW'(deff - 13'h0001)) ?
                '0 : s_q.wptr + 12'h001; // R10
        end
        if (pop) begin
            s_d.rptr = (s_q.rptr == ESF_AW'(deff - 13'h0001)) ?
                '0 : s_q.rptr + 12'h001; // R10
        end
        if (push && !pop) begin
            s_d.cnt = s_q.cnt + 13'h0001;
        end else if (pop && !push) begin
            s_d.cnt = s_q.cnt - 13'h0001;
        end
        // read data is captured in setup so a read-clear stays exact
        if (setup) begin
            s_d.prdata = rd_mux;
            s_d.pslverr = !mapped;
        end
        if (access && pwrite) begin
            unique case (paddr)
                ESF_CTRL_ADR:
                    s_d.ctrl = esf_ctrl_s'(pwdata[$bits(esf_ctrl_s)-1:0]);
                ESF_DEPTH_ADR: s_d.depth = pwdata[ESF_CW-1:0]; // R7
                ESF_AE_ADR: s_d.ae_thr = pwdata[ESF_CW-1:0]; // R8
                ESF_AF_ADR: s_d.af_thr = pwdata[ESF_CW-1:0]; // R8
                ESF_IMSK_ADR: s_d.imask = esf_irq_s'(pwdata[3:0]);
                default: ;
            endcase
            // reshaping the queue empties it; stale pointers would lie
            if (paddr == ESF_CTRL_ADR || paddr == ESF_DEPTH_ADR) begin
                s_d.wptr = '0;
                s_d.rptr = '0;
                s_d.cnt = '0;
            end
        end
        // flags follow the next count so they never lag a push or pop
        s_d.flags.empty = (s_d.cnt == '0); // R9
        s_d.flags.full = s_d.ctrl.fifo_en && (s_d.cnt >= deff); // R9
        s_d.flags.ae = (s_d.cnt <= s_d.ae_thr); // R13
        s_d.flags.af = s_d.ctrl.fifo_en
            && (s_d.cnt >= s_d.af_thr); // R13
    end

    // ------------------------------------------------------------
    // sticky interrupt status, cleared by reading it
    // ------------------------------------------------------------
    // only bits that the read returned are cleared; a new event wins
    always_comb begin
        clr = '0;
        if (access && !pwrite && paddr == ESF_IST_ADR) begin
            clr = esf_irq_s'(s_q.prdata[3:0]);
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
            s_q.depth <= ESF_DEPTH_RST;
            s_q.ae_thr <= ESF_AE_RST;
            s_q.af_thr <= ESF_AF_RST;
            s_q.flags.empty <= 1'b1;
            s_q.flags.ae <= 1'b1;
        end else begin
            s_q <= s_d;
            s_q.istat <= (s_q.istat & ~clr) | ev;
        end
    end

    // ------------------------------------------------------------
    // storage port steering
    // ------------------------------------------------------------
    // preload from the test port wins the write port in every mode
    always_comb begin
        core_we = tport.en || push || (!s_q.ctrl.fifo_en && wport.en);
        core_wdata = tport.en ? tport.data : wport.data; // R5
        if (tport.en) begin
            waddr = tport.addr; // R5
        end else if (s_q.ctrl.fifo_en) begin
            waddr = s_q.wptr; // R6
        end else begin
            waddr = wport.addr; // R3
        end
        raddr = s_q.ctrl.fifo_en ? s_q.rptr : rport.addr; // R6
        core_re = pop || (!s_q.ctrl.fifo_en && rport.en);
        // power-of-two depths let a mask keep addresses in range
        wbase = ESF_CW'((waddr & ESF_AW'(dmax - 13'h0001)) * wwid); // R1
        rbase = ESF_CW'((raddr & ESF_AW'(rdmax - 13'h0001)) * rwid); // R1
    end

    esf_core #(
        .CAP_BITS(CAP_BITS)
    ) u_core (
        .clk(clk),
        .we(core_we),
        .wbase(wbase),
        .wwid(wwid),
        .wdata(core_wdata),
        .re(core_re),
        .rbase(rbase),
        .rwid(rwid),
        .rdata(rd_data)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // flags are exported so fabric can chain blocks deeper or wider
    assign flags = s_q.flags; // R11
    assign rd_valid = s_q.rd_valid;
    assign prdata = s_q.prdata;
    assign pslverr = s_q.pslverr && access;
    assign pready = 1'b1;
    assign irq = |(s_q.istat & s_q.imask);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    full_push_a: assert property (
        s_q.flags.full && wport.en |=> s_q.wptr == $past(s_q.wptr)) // R12
        else $error("push accepted while full");

    empty_pop_a: assert property (
        s_q.ctrl.fifo_en && s_q.flags.empty && rport.en
        |=> s_q.rptr == $past(s_q.rptr) && !s_q.rd_valid) // R12
        else $error("pop accepted while empty");

    wptr_step_a: assert property (push && !(access && pwrite)
        |=> s_q.wptr == $past(s_q.wptr) + 12'h001 || s_q.wptr == '0) // R10
        else $error("write pointer did not advance");

    cnt_cap_a: assert property (
        s_q.cnt <= dmax && s_q.cnt <= 13'(ESF_CAP_BITS)) // R1
        else $error("count exceeds capacity");

    geom_a: assert property (32'(wwid) * 32'(dmax) <= 32'(ESF_CAP_BITS)
        && 32'(wwid) * 32'(dmax) >= 32'(ESF_CAP_BITS) - 32'h200) // R2
        else $error("aspect ratio outside the block");

    not_empty_a: assert property (
        push && !pop && !(access && pwrite) |=> !s_q.flags.empty) // R9
        else $error("empty after accepted push");

    not_full_a: assert property (
        pop && !push |=> !s_q.flags.full) // R9
        else $error("full after accepted pop");

    ae_level_a: assert property (
        s_q.cnt <= s_q.ae_thr |-> s_q.flags.ae) // R13
        else $error("almost empty missing at threshold");

    af_level_a: assert property (s_q.ctrl.fifo_en
        && s_q.cnt >= s_q.af_thr |-> s_q.flags.af) // R8
        else $error("almost full missing at threshold");

    pop_data_a: assert property (pop |=> rd_valid) // R6
        else $error("no read data after pop");

    ovf_irq_a: assert property (s_q.flags.full && wport.en // R12
        && s_q.imask.ovf |=> irq)
        else $error("overflow did not raise interrupt");

    // ------------------------------------------------------------
    // counter and status bookkeeping
    // ------------------------------------------------------------
    // ctrl and depth writes flush the queue, so all register writes are excluded here
    cnt_up_a: assert property ( // R10
        push && !pop && !(access && pwrite)
        |=> s_q.cnt == $past(s_q.cnt) + 13'h0001)
        else $error("count did not rise after push");

    cnt_down_a: assert property ( // R10
        pop && !push && !(access && pwrite)
        |=> s_q.cnt == $past(s_q.cnt) - 13'h0001)
        else $error("count did not fall after pop");

    rptr_step_a: assert property (pop && !(access && pwrite) // R10
        |=> s_q.rptr == $past(s_q.rptr) + 12'h001 || s_q.rptr == '0)
        else $error("read pointer did not advance");

    ovf_sticky_a: assert property (ev.ovf |=> s_q.istat.ovf) // R12
        else $error("overflow status bit not set");

    ram_read_a: assert property ( // R3
        !s_q.ctrl.fifo_en && rport.en && !(access && pwrite)
        |=> rd_valid)
        else $error("ram read gave no data strobe");

    depth_bound_a: assert property (s_q.ctrl.fifo_en // R7
        |-> s_q.cnt <= deff)
        else $error("count beyond programmed depth");

    fill_c: cover property (s_q.ctrl.fifo_en && s_q.flags.full);
    drain_c: cover property (s_q.flags.full ##[1:600] s_q.flags.empty);
    mixed_c: cover property (!s_q.ctrl.fifo_en && rd_valid
        && s_q.ctrl.rd_w != s_q.ctrl.wr_w);
    irq_c: cover property (irq);

endmodule : esf_top

// ==== esf_fabric.sv ====
// esf_fabric: model of the fabric user logic on the block's data ports
// assumes the block samples its fabric and test ports on the rising clk
`timescale 1ns/1ps
module esf_fabric
    import esf_pkg::*;
(
    input wire logic clk,
    output esf_wport_s wport,
    output esf_rport_s rport,
    output esf_wport_s tport,
    input wire logic [ESF_DW-1:0] rd_data,
    input wire logic rd_valid
);
    // ------------------------------------------------------------
    // port idle levels
    // ------------------------------------------------------------
    initial begin
        wport = '0;
        rport = '0;
        tport = '0;
    end

    // one write; released lines show inverted values, never stale ones
    task automatic wr(input logic [ESF_AW-1:0] a,
                      input logic [ESF_DW-1:0] d, input logic pre);
        @(posedge clk);
        if (pre) begin
            tport <= '{1'b1, a, d};
        end else begin
            wport <= '{1'b1, a, d};
        end
        @(posedge clk);
        if (pre) begin
            tport <= '{1'b0, ~a, ~d};
        end else begin
            wport <= '{1'b0, ~a, ~d};
        end
    endtask : wr

    // one read; waits a few cycles only, so a missing pulse shows as v=0
    task automatic rd(input logic [ESF_AW-1:0] a, output logic v,
                      output logic [ESF_DW-1:0] d);
        int n;
        @(posedge clk);
        rport <= '{1'b1, a};
        @(posedge clk);
        rport <= '{1'b0, ~a};
        #1;
        n = 0;
        while (rd_valid !== 1'b1 && n < 3) begin
            @(posedge clk);
            #1;
            n++;
        end
        v = rd_valid;
        d = rd_data;
    endtask : rd
endmodule : esf_fabric

// ==== testbench.sv ====
// testbench: apb register tests plus ram and fifo traffic via esf_fabric
// assumes esf_top with zero-wait apb and one clk domain
`timescale 1ns/1ps
module testbench
    import esf_pkg::*;
;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, irq, rd_valid;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rq;
    logic re;
    esf_wport_s wport, tport;
    esf_rport_s rport;
    esf_flags_s flags;
    logic [ESF_DW-1:0] rd_data;
    int err_count = 0;
    int tests_run = 0;

    esf_top dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .wport(wport),
        .rport(rport), .rd_data(rd_data), .rd_valid(rd_valid),
        .tport(tport), .flags(flags));
    esf_fabric fab (.clk(clk), .wport(wport), .rport(rport), .tport(tport),
        .rd_data(rd_data), .rd_valid(rd_valid));

    // ------------------------------------------------------------
    // clock and helpers
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // apb transfer; waits for pready rather than assuming zero waits
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            err_count++;
        end
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // let the access edge settle before outputs are compared
        #1;
    endtask : apb

    // status word for depth 4, thresholds ae 1 and af 3
    function automatic logic [31:0] stat(int c);
        return {15'h0, 13'(c), c >= 3, c <= 1, c == 4, c == 0};
    endfunction : stat

    task automatic final_report;
        if (err_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report

    // watchdog; whole run needs well under a thousand transfers
    initial begin
        repeat (30000) @(posedge clk);
        err_count++;
        final_report();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic v;
        logic [ESF_DW-1:0] d, m;
        int dep;
        int wt[5];
        wt = '{1, 2, 4, 9, 18};
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        apb(0, ESF_STAT_ADR, 0);
        check(rq, stat(0));
        apb(0, ESF_AE_ADR, 0);
        check(rq, 32'h1);
        apb(0, ESF_AF_ADR, 0);
        check(rq, 32'hff);
        apb(1, 8'h1c, 32'hffff_ffff);
        check({31'h0, re}, 32'h1);
        // ram mode: write x4, read back x1, lsb first
        apb(1, ESF_CTRL_ADR, 32'h4);
        fab.wr(12'h0, 18'ha, 1'b0);
        for (int i = 0; i < 4; i++) begin
            fab.rd(12'(i), v, d);
            check({13'h0, v, d}, 32'h40000 | 32'(i % 2));
        end
        // every aspect ratio: top word and address wrap at depth
        for (int k = 0; k < 5; k++) begin
            dep = 4096 >> k;
            m = 18'((1 << wt[k]) - 1);
            apb(1, ESF_CTRL_ADR, 32'(k * 18));
            fab.wr(12'(dep - 1), 18'h2a5a5 & m, 1'b0);
            fab.wr(12'h0, 18'h15a5a & m, 1'b0);
            fab.rd(12'(dep - 1), v, d);
            check({13'h0, v, d}, 32'h40000 | 32'(18'h2a5a5 & m));
            fab.rd(12'(dep), v, d);
            check({13'h0, v, d}, 32'h40000 | 32'(18'h15a5a & m));
        end
        fab.wr(12'h5, 18'h3c3c3, 1'b1);
        fab.rd(12'h5, v, d);
        check({13'h0, v, d}, 32'h7c3c3);
        // fifo x9, depth 4; fill past full, then drain past empty
        apb(1, ESF_DEPTH_ADR, 32'h4);
        apb(1, ESF_AE_ADR, 32'h1);
        apb(1, ESF_AF_ADR, 32'h3);
        apb(1, ESF_CTRL_ADR, 32'h7);
        apb(0, ESF_IST_ADR, 0);
        apb(1, ESF_IMSK_ADR, 32'hf);
        for (int i = 1; i <= 5; i++) begin
            fab.wr(12'h0, 18'(i * 37), 1'b0);
            apb(0, ESF_STAT_ADR, 0);
            check(rq, stat(i > 4 ? 4 : i));
            check({28'h0, flags}, stat(i > 4 ? 4 : i) & 32'hf);
        end
        check({31'h0, irq}, 32'h1);
        apb(0, ESF_IST_ADR, 0);
        check(rq, 32'h5);
        check({31'h0, irq}, 32'h0);
        for (int i = 1; i <= 5; i++) begin
            fab.rd(12'h0, v, d);
            if (i < 5) begin
                check({13'h0, v, d}, 32'h40000 | 32'(i * 37));
            end else begin
                check({31'h0, v}, 32'h0);
            end
            apb(0, ESF_STAT_ADR, 0);
            check(rq, stat(i < 5 ? 4 - i : 0));
        end
        apb(0, ESF_IST_ADR, 0);
        check(rq, 32'ha);
        // masked event: status bit set, no interrupt
        apb(1, ESF_IMSK_ADR, 32'h0);
        fab.rd(12'h0, v, d);
        check({31'h0, irq}, 32'h0);
        apb(0, ESF_IST_ADR, 0);
        check(rq, 32'h2);
        final_report();
    end
endmodule : testbench
